/* core/host_bridge_system_config.sv */
`timescale 1ns/1ps
`include "host_bridge_consts.svh"

// Notes on behaviour
// - Capabilities pointer reads constant a0, read-only.
// - System configuration is 16 bits at 50-51.
// - Bit 15 set disables write snoop handshake.
// - Bit 14 shows sampled strap; 1 means 60MHz.
// - Refresh interval follows the strapped frequency.
// - Bits 10,9 set: PCI aperture accesses unclaimed.
// - PCI disable ignored while global enable clear.
// - Bit 9 clear refuses all aperture accesses.
// - Bits 8:7 select DRAM integrity mode.
// - Bit 6 set enters ECC diagnostic mode.
// - Aperture range comes from base address register.
module host_bridge_system_config #(
   parameter int unsigned REFRESH_COUNT_60 = (`REFRESH_60_NS) / (`CLK_PERIOD_NS),
   parameter int unsigned REFRESH_COUNT_66 = (`REFRESH_66_NS) / (`CLK_PERIOD_NS)
) (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Configuration access port.
   input  wire logic [7:0]  cfg_addr,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   output logic             cfg_rvalid,
   // Strap pin.
   input  wire logic        memory_check_bit0_pin,
   // Aperture hits from the decode of the aperture base register.
   input  wire logic        cpu_aperture_hit,
   input  wire logic        pci_aperture_hit,
   input  wire logic        gfx_aperture_hit,
   // Aperture access decisions.
   output logic             cpu_aperture_allow,
   output logic             pci_aperture_claim,
   output logic             gfx_aperture_allow,
   // Write snoop and memory controls.
   output logic             write_snoop_complete_enable,
   output logic             ecc_generate_enable,
   output logic             ecc_check_enable,
   output logic             ecc_correct_enable,
   output logic             byte_write_enable,
   output logic             ecc_diag_mode_enable,
   output logic             host_is_60mhz,
   output logic             refresh_req
);

   logic [15:0]                        cfg_q;
   logic [15:0]                        cfg_d;
   logic [31:0]                        rdata_q;
   logic [31:0]                        rdata_d;
   logic                               rvalid_q;
   logic                               rvalid_d;
   logic                               sync1_q;
   logic                               sync2_q;
   logic                               freq_q;
   logic                               freq_d;
   logic [1:0]                         settle_q;
   logic [1:0]                         settle_d;
   host_bridge_pkg::strap_state_e      strap_q;
   host_bridge_pkg::strap_state_e      strap_d;
   host_bridge_pkg::dram_integrity_mode_e dim;
   logic                               ap_global;

   // Writable-bit mask held as a constant so its byte lanes can be sliced.
   localparam logic [15:0]             RW_MASK = `SC_RW_MASK;

   // Matches a configuration access against one dword.
   function automatic logic hits_dword(input logic [7:0] addr, input logic [7:0] offset);
      hits_dword = (addr[7:`DWORD_ADDR_LSB] == offset[7:`DWORD_ADDR_LSB]);
   endfunction

   // ----------------------------------------------------------------------------
   // System configuration register
   // ----------------------------------------------------------------------------

   // Byte lanes 0 and 1 update only writable bits; the strap bit is merged on read.
   always_comb begin
      cfg_d = cfg_q;
      if (cfg_wr && hits_dword(cfg_addr, `SYS_CFG_OFFSET)) begin
         if (cfg_byte_en[0]) begin
            cfg_d[7:0] = cfg_wdata[7:0] & RW_MASK[7:0];
         end
         if (cfg_byte_en[1]) begin
            cfg_d[15:8] = cfg_wdata[15:8] & RW_MASK[15:8];
         end
      end
   end

   // Register of the configuration bits.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_q <= `SC_RESET_VALUE;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------

   // Read data is returned one cycle after the strobe; unmapped dwords read zero.
   always_comb begin
      rdata_d  = rdata_q;
      rvalid_d = cfg_rd;
      if (cfg_rd) begin
         rdata_d = 32'h0000_0000;
         if (hits_dword(cfg_addr, `CAP_PTR_OFFSET)) begin
            rdata_d[7:0] = `CAP_PTR_VALUE;
         end else if (hits_dword(cfg_addr, `SYS_CFG_OFFSET)) begin
            rdata_d[15:0] = cfg_q;
            rdata_d[`SC_HOST_FREQ_BIT] = freq_q;
         end
      end
   end

   // Registers of the read path.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_q  <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign cfg_rdata  = rdata_q;
   assign cfg_rvalid = rvalid_q;

   // ----------------------------------------------------------------------------
   // Host frequency strap
   // ----------------------------------------------------------------------------

   // Two-stage synchroniser on the pin; reset gives it a known start.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= memory_check_bit0_pin;
         sync2_q <= sync1_q;
      end
   end

   // The strap is taken once the synchroniser has refilled after release, then held.
   always_comb begin
      strap_d  = strap_q;
      settle_d = settle_q;
      freq_d   = freq_q;
      case (strap_q)
         host_bridge_pkg::STRAP_SETTLE: begin
            settle_d = settle_q + 2'h1;
            if (settle_q == `STRAP_SETTLE) begin
               freq_d  = sync2_q;
               strap_d = host_bridge_pkg::STRAP_HOLD;
            end
         end
         host_bridge_pkg::STRAP_HOLD: begin
            settle_d = settle_q;
         end
         default: begin
            strap_d = host_bridge_pkg::STRAP_SETTLE;
         end
      endcase
   end

   // Registers of the strap capture.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         strap_q  <= host_bridge_pkg::STRAP_SETTLE;
         settle_q <= 2'h0;
         freq_q   <= 1'b0;
      end else begin
         strap_q  <= strap_d;
         settle_q <= settle_d;
         freq_q   <= freq_d;
      end
   end

   assign host_is_60mhz = freq_q;

   // ----------------------------------------------------------------------------
   // Aperture gating
   // ----------------------------------------------------------------------------

   // Software sets the global enable only after the range and table are ready.
   assign ap_global = cfg_q[`SC_AP_GLOBAL_BIT];

   // Hits come from the range held by the base and size registers elsewhere.
   assign cpu_aperture_allow = cpu_aperture_hit & ap_global;
   assign gfx_aperture_allow = gfx_aperture_hit & ap_global;
   assign pci_aperture_claim = pci_aperture_hit & ap_global & ~cfg_q[`SC_PCI_AP_DIS_BIT];

   // ----------------------------------------------------------------------------
   // Snoop handshake and memory integrity
   // ----------------------------------------------------------------------------

   // Handshake runs unless the disable bit is set.
   assign write_snoop_complete_enable = ~cfg_q[`SC_WSC_DIS_BIT];

   // The reserved mode code behaves as non-ECC.
   assign dim = host_bridge_pkg::dram_integrity_mode_e'(cfg_q[`SC_DIM_HI_BIT:`SC_DIM_LO_BIT]);
   assign ecc_generate_enable = (dim == host_bridge_pkg::DIM_FULL);
   assign ecc_correct_enable  = (dim == host_bridge_pkg::DIM_FULL);
   assign ecc_check_enable    = (dim == host_bridge_pkg::DIM_FULL) || (dim == host_bridge_pkg::DIM_CHECK);
   assign byte_write_enable   = (dim == host_bridge_pkg::DIM_NONE) || (dim == host_bridge_pkg::DIM_RSVD);

   // Diagnostic mode follows bit 6 directly.
   assign ecc_diag_mode_enable = cfg_q[`SC_ECC_DIAG_BIT];

   // ----------------------------------------------------------------------------
   // Refresh
   // ----------------------------------------------------------------------------

   // The interval count is chosen by the strapped frequency.
   refresh_timer #(
      .COUNT_60 (REFRESH_COUNT_60),
      .COUNT_66 (REFRESH_COUNT_66)
   ) u_refresh (
      .sys_clk       (sys_clk),
      .sys_rst       (sys_rst),
      .host_is_60mhz (freq_q),
      .refresh_req   (refresh_req)
   );

endmodule

/* core/host_bridge_consts.svh */
`ifndef HOST_BRIDGE_CONSTS_SVH
`define HOST_BRIDGE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Configuration offsets
// ----------------------------------------------------------------------------
`define CAP_PTR_OFFSET     8'h34
`define SYS_CFG_OFFSET     8'h50
`define CAP_PTR_VALUE      8'ha0
`define DWORD_ADDR_LSB     2

// ----------------------------------------------------------------------------
// System configuration field positions
// ----------------------------------------------------------------------------
`define SC_WSC_DIS_BIT     15
`define SC_HOST_FREQ_BIT   14
`define SC_PCI_AP_DIS_BIT  10
`define SC_AP_GLOBAL_BIT   9
`define SC_DIM_HI_BIT      8
`define SC_DIM_LO_BIT      7
`define SC_ECC_DIAG_BIT    6
`define SC_RW_MASK         16'h87c0
`define SC_RESET_VALUE     16'h0000

// ----------------------------------------------------------------------------
// Integrity mode codes and strap timing
// ----------------------------------------------------------------------------
`define DIM_NON_ECC        2'h0
`define DIM_CHECK_ONLY     2'h1
`define DIM_RESERVED       2'h2
`define DIM_ECC_FULL       2'h3
`define STRAP_SETTLE       2'h2

// ----------------------------------------------------------------------------
// Refresh timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      100
`define REFRESH_60_NS      15000
`define REFRESH_66_NS      15600

`endif

/* core/host_bridge_pkg.sv */
package host_bridge_pkg;

   // Decoded DRAM integrity modes.
   typedef enum logic [1:0] {
      DIM_NONE,
      DIM_CHECK,
      DIM_RSVD,
      DIM_FULL
   } dram_integrity_mode_e;

   // Strap capture sequence.
   typedef enum logic [1:0] {
      STRAP_SETTLE,
      STRAP_HOLD
   } strap_state_e;

endpackage

/* core/refresh_timer.sv */
`timescale 1ns/1ps
`include "host_bridge_consts.svh"

module refresh_timer #(
   parameter int unsigned COUNT_60 = (`REFRESH_60_NS) / (`CLK_PERIOD_NS),
   parameter int unsigned COUNT_66 = (`REFRESH_66_NS) / (`CLK_PERIOD_NS),
   parameter int unsigned CNT_W    = 16
) (
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Frequency select and request.
   input  wire logic host_is_60mhz,
   output logic      refresh_req
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             req_q;
   logic             req_d;
   logic [CNT_W-1:0] limit;

   // ----------------------------------------------------------------------------
   // Interval counter
   // ----------------------------------------------------------------------------

   // The strapped frequency picks the interval, rounded down so refresh is never late.
   always_comb begin
      limit = host_is_60mhz ? CNT_W'(COUNT_60 - 1) : CNT_W'(COUNT_66 - 1);
      req_d = 1'b0;
      cnt_d = cnt_q + CNT_W'(1);
      if (cnt_q >= limit) begin
         cnt_d = '0;
         req_d = 1'b1;
      end
   end

   // Registers of the interval counter.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         req_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         req_q <= req_d;
      end
   end

   assign refresh_req = req_q;

endmodule

/* test/host_bridge_system_config_assertions.sv */
`timescale 1ns/1ps
module host_bridge_system_config_checker #(
   parameter int unsigned REFRESH_COUNT_60 = 150,
   parameter int unsigned REFRESH_COUNT_66 = 156
) (
   // Clock, reset and register port.
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  cfg_addr,
   input wire logic        cfg_wr,
   input wire logic        cfg_rd,
   input wire logic [3:0]  cfg_byte_en,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic        cfg_rvalid,
   // Aperture, memory and refresh signals.
   input wire logic        cpu_aperture_hit,
   input wire logic        gfx_aperture_hit,
   input wire logic        cpu_aperture_allow,
   input wire logic        pci_aperture_claim,
   input wire logic        gfx_aperture_allow,
   input wire logic        write_snoop_complete_enable,
   input wire logic        ecc_generate_enable,
   input wire logic        ecc_check_enable,
   input wire logic        ecc_correct_enable,
   input wire logic        byte_write_enable,
   input wire logic        ecc_diag_mode_enable,
   input wire logic        host_is_60mhz,
   input wire logic        refresh_req
);
   logic [15:0] gap_q;
   logic [15:0] gap_d;
   logic        seen_q;
   logic        seen_d;
   // Cycles since the last refresh pulse.
   always_comb begin
      gap_d = refresh_req ? 16'h0001 : gap_q + 16'h0001;
      seen_d = seen_q | refresh_req;
   end
   // Registers the interval counter.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         gap_q <= 16'h0000;
         seen_q <= 1'b0;
      end else begin
         gap_q <= gap_d;
         seen_q <= seen_d;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence read_at(logic [5:0] dw);
      cfg_rd && cfg_addr[7:2] == dw;
   endsequence
   sequence write_cfg;
      cfg_wr && cfg_addr[7:2] == 6'h14;
   endsequence
   a_pointer_read: assert property (read_at(6'h0d) |=> cfg_rdata == 32'h000000a0)
      else $error("pointer read wrong");
   a_rvalid_follows: assert property (cfg_rvalid == $past(cfg_rd))
      else $error("read valid wrong");
   a_cfg_read_fields: assert property (read_at(6'h14) |=> cfg_rdata[31:16] == 16'h0000 &&
      cfg_rdata[13:11] == 3'h0 && cfg_rdata[5:0] == 6'h00 && cfg_rdata[14] == $past(host_is_60mhz) &&
      cfg_rdata[15] != $past(write_snoop_complete_enable) && cfg_rdata[6] == $past(ecc_diag_mode_enable))
      else $error("config read wrong");
   a_unmapped_zero: assert property (cfg_rd && cfg_addr[7:2] != 6'h0d && cfg_addr[7:2] != 6'h14
      |=> cfg_rdata == 32'h0) else $error("unmapped read wrong");
   a_snoop_write: assert property (write_cfg and cfg_byte_en[1]
      |=> write_snoop_complete_enable != $past(cfg_wdata[15])) else $error("snoop enable wrong");
   a_diag_write: assert property (write_cfg and cfg_byte_en[0]
      |=> ecc_diag_mode_enable == $past(cfg_wdata[6])) else $error("diag mode wrong");
   a_mode_check: assert property (write_cfg and cfg_byte_en[1:0] == 2'h3
      |=> ecc_check_enable == $past(cfg_wdata[7])) else $error("check enable wrong");
   a_mode_decode: assert property (byte_write_enable != ecc_check_enable &&
      ecc_generate_enable == ecc_correct_enable && (!ecc_generate_enable || ecc_check_enable))
      else $error("mode decode wrong");
   a_aperture_hits: assert property ((cpu_aperture_hit && gfx_aperture_hit)
      |-> cpu_aperture_allow == gfx_aperture_allow) else $error("aperture allow wrong");
   a_pci_global: assert property (pci_aperture_claim && cpu_aperture_hit
      |-> cpu_aperture_allow) else $error("pci claim wrong");
   a_refresh_period: assert property (refresh_req && seen_q
      |-> gap_q == (host_is_60mhz ? REFRESH_COUNT_60 : REFRESH_COUNT_66)) else $error("refresh period wrong");
endmodule
bind host_bridge_system_config host_bridge_system_config_checker #(.REFRESH_COUNT_60(REFRESH_COUNT_60),
   .REFRESH_COUNT_66(REFRESH_COUNT_66)) checker_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_addr(cfg_addr),
   .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
   .cfg_rvalid(cfg_rvalid), .cpu_aperture_hit(cpu_aperture_hit), .gfx_aperture_hit(gfx_aperture_hit),
   .cpu_aperture_allow(cpu_aperture_allow), .pci_aperture_claim(pci_aperture_claim),
   .gfx_aperture_allow(gfx_aperture_allow), .write_snoop_complete_enable(write_snoop_complete_enable),
   .ecc_generate_enable(ecc_generate_enable), .ecc_check_enable(ecc_check_enable),
   .ecc_correct_enable(ecc_correct_enable), .byte_write_enable(byte_write_enable),
   .ecc_diag_mode_enable(ecc_diag_mode_enable), .host_is_60mhz(host_is_60mhz), .refresh_req(refresh_req));

/* test/tb_host_bridge_system_config.sv */
`timescale 1ns/1ps
module tb_host_bridge_system_config;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic [3:0]  be = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        rvalid, cpu_al, pci_cl, gfx_al, wsc, gen, chk, cor, bwr, diag, is60, rfr;
   logic        strap = 1'b1;
   logic        hit = 1'b0;
   int          fail_count = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          pulses = 0;
   host_bridge_system_config #(.REFRESH_COUNT_60(5), .REFRESH_COUNT_66(8)) host_bridge_system_config_i (
      .sys_clk(clk), .sys_rst(rst), .cfg_addr(addr), .cfg_wr(wr_s), .cfg_rd(rd_s), .cfg_byte_en(be),
      .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .memory_check_bit0_pin(strap),
      .cpu_aperture_hit(hit), .pci_aperture_hit(hit), .gfx_aperture_hit(hit), .cpu_aperture_allow(cpu_al),
      .pci_aperture_claim(pci_cl), .gfx_aperture_allow(gfx_al), .write_snoop_complete_enable(wsc),
      .ecc_generate_enable(gen), .ecc_check_enable(chk), .ecc_correct_enable(cor), .byte_write_enable(bwr),
      .ecc_diag_mode_enable(diag), .host_is_60mhz(is60), .refresh_req(rfr));
   // ---------------------------
   // Clock, pulse count, timeout
   // ---------------------------
   initial begin
      forever #50 clk = ~clk;
   end
   // Counts refresh pulses and cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (rfr === 1'b1) pulses++;
      if (cycles == 3000) begin
         fail_count++;
         final_report();
      end
   end
   // ---------------------------
   // Access and compare tasks
   // ---------------------------
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task chk1(input string name, input logic seen, input logic exp);
      check(name, {31'h0, seen}, {31'h0, exp});
   endtask
   task step;
      @(posedge clk);
      #1;
   endtask
   // A strobe is one cycle wide and is followed by an idle cycle.
   task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      addr = a;
      be = b;
      wdata = d;
      wr_s = 1'b1;
      step();
      wr_s = 1'b0;
      step();
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      addr = a;
      rd_s = 1'b1;
      step();
      rd_s = 1'b0;
      chk1("rvalid", rvalid, 1'b1);
      check("rdata", rdata, exp);
      step();
   endtask
   task do_reset;
      rst = 1'b1;
      repeat (10) step();
      rst = 1'b0;
      repeat (6) step();
   endtask
   // ---------------------------
   // Main sequence
   // ---------------------------
   initial begin
      do_reset();
      chk1("is60", is60, 1'b1);
      chk1("snoop", wsc, 1'b1);
      rd(8'h34, 32'h000000a0);
      rd(8'h50, 32'h00004000);
      rd(8'h54, 32'h00000000);
      wr(8'h34, 4'hf, 32'hffffffff);
      rd(8'h34, 32'h000000a0);
      wr(8'h50, 4'hf, 32'hffffffff);
      rd(8'h50, 32'h0000c7c0);
      chk1("snoop", wsc, 1'b0);
      chk1("diag", diag, 1'b1);
      wr(8'h50, 4'h3, 32'h0);
      chk1("diag", diag, 1'b0);
      wr(8'h50, 4'h1, 32'hffffffff);
      rd(8'h50, 32'h000040c0);
      // Every integrity mode code, reserved one included.
      for (int m = 0; m < 4; m++) begin
         wr(8'h50, 4'h3, m << 7);
         chk1("gen", gen, m == 3);
         chk1("chk", chk, m[0]);
         chk1("cor", cor, m == 3);
         chk1("bytewr", bwr, !m[0]);
      end
      // The range and table count as ready here, before the loop below sets the global enable.
      hit = 1'b1;
      // All four settings of the global aperture enable and the PCI aperture disable.
      for (int k = 0; k < 4; k++) begin
         wr(8'h50, 4'h3, k << 9);
         chk1("cpu", cpu_al, k[0]);
         chk1("gfx", gfx_al, k[0]);
         chk1("pci", pci_cl, k[0] & !k[1]);
      end
      hit = 1'b0;
      step();
      chk1("cpu", cpu_al, 1'b0);
      pulses = 0;
      repeat (50) step();
      check("pulses", pulses, 32'h0000000a);
      strap = 1'b0;
      do_reset();
      chk1("is60", is60, 1'b0);
      pulses = 0;
      repeat (80) step();
      check("pulses", pulses, 32'h0000000a);
      rd(8'h50, 32'h00000000);
      final_report();
   end
endmodule
